//--- inc/rla_pkg.sv
// rla_pkg: offsets, field positions, reset values and carriers of the
// per-port remote link identity / alias register group.
// assumes a byte-wide local register port with 8-bit offsets.
package rla_pkg;

  // port count of the hub and width of the port-select value
  localparam int MAX_PORTS   = 4;
  localparam int PORT_SEL_W  = 2;

  // register offsets
  localparam logic [7:0] OFS_FWD_CFG  = 8'h59;
  localparam logic [7:0] OFS_IDENTITY = 8'h5B;
  localparam logic [7:0] OFS_ALIAS    = 8'h5C;
  localparam logic [7:0] OFS_TGT0     = 8'h5D;
  localparam logic [7:0] OFS_TGT1     = 8'h5E;

  // field positions
  localparam int OVERRIDE_BIT = 7;
  localparam int GPIO_LSB     = 0;
  localparam int ADDR_LSB     = 1;
  localparam int FREEZE_BIT   = 0;
  localparam int AUTO_ACK_BIT = 0;

  // reset values
  localparam logic [7:0] RST_FWD_CFG  = 8'h00;
  localparam logic [7:0] RST_IDENTITY = 8'h00;
  localparam logic [7:0] RST_ALIAS    = 8'h00;
  localparam logic [7:0] RST_TGT      = 8'h00;

  // alias value that switches the decoder off
  localparam logic [6:0] ALIAS_OFF = 7'h00;

  // one port's stored fields
  typedef struct packed {
    logic       override;
    logic [1:0] gpio_count;
    logic [6:0] identity;
    logic       freeze;
    logic [6:0] alias_addr;
    logic       auto_ack;
    logic [6:0] tgt0;
    logic [6:0] tgt1;
  } rla_port_regs_t;

  localparam rla_port_regs_t PORT_RESET = '{
    override:   RST_FWD_CFG[OVERRIDE_BIT],
    gpio_count: RST_FWD_CFG[GPIO_LSB +: 2],
    identity:   RST_IDENTITY[ADDR_LSB +: 7],
    freeze:     RST_IDENTITY[FREEZE_BIT],
    alias_addr: RST_ALIAS[ADDR_LSB +: 7],
    auto_ack:   RST_ALIAS[AUTO_ACK_BIT],
    tgt0:       RST_TGT[ADDR_LSB +: 7],
    tgt1:       RST_TGT[ADDR_LSB +: 7]
  };

  // values pushed by the remote serializer over the forward channel
  typedef struct packed {
    logic       gpio_valid;
    logic [1:0] gpio_count;
    logic       id_valid;
    logic [6:0] identity;
  } rla_fwd_load_t;

  // local i2c address presented for decoding
  typedef struct packed {
    logic       valid;
    logic       is_write;
    logic [6:0] addr;
  } rla_i2c_req_t;

  // routing decision for one transaction
  typedef struct packed {
    logic       remote;
    logic       ack;
    logic [6:0] addr;
  } rla_route_t;

endpackage

//--- hw/rla_alias_match.sv
// rla_alias_match: combinational address decode of one receive port.
// assumes the stored fields come from rla_regs and the request is stable.
`timescale 1ns/10ps
module rla_alias_match (
  input  wire rla_pkg::rla_port_regs_t regs,
  input  wire logic                    pass_all,
  input  wire logic [6:0]              tgt_alias0,
  input  wire logic [6:0]              tgt_alias1,
  input  wire rla_pkg::rla_i2c_req_t   req,
  output rla_pkg::rla_route_t          route
);

  logic ser_hit;
  logic t0_hit;
  logic t1_hit;

  // alias compares; a zero alias never matches
  assign ser_hit = req.valid && (regs.alias_addr != rla_pkg::ALIAS_OFF)
                   && (req.addr == regs.alias_addr);
  assign t0_hit  = req.valid && (tgt_alias0 != rla_pkg::ALIAS_OFF)
                   && (req.addr == tgt_alias0);
  assign t1_hit  = req.valid && (tgt_alias1 != rla_pkg::ALIAS_OFF)
                   && (req.addr == tgt_alias1);

  // remap, auto-ack and pass-through choice
  always_comb begin
    route = '0;
    if (ser_hit) begin
      route.remote = 1'b1;
      route.addr   = regs.tgt0;
      route.ack    = req.is_write && regs.auto_ack;
    end else if (t0_hit) begin
      route.remote = 1'b1;
      route.addr   = regs.tgt0;
    end else if (t1_hit) begin
      route.remote = 1'b1;
      route.addr   = regs.tgt1;
    end else if (req.valid && pass_all) begin
      route.remote = 1'b1;
      route.addr   = req.addr;
    end
    // otherwise nothing forwarded, nothing acknowledged
  end

endmodule

//--- hw/rla_regs.sv
// rla_regs: per-port remote link configuration, identity, alias and
// target remap registers, plus the routing decode they steer.
// assumes a byte register port from the local i2c controller, the
// port-select value from elsewhere, and forward-channel load strobes.
// no buffering: each answer stands in its register until replaced.
`timescale 1ns/10ps
module rla_regs #(
  parameter int NUM_PORTS = rla_pkg::MAX_PORTS
) (
  input  wire  logic                                      clk_sys,
  input  wire  logic                                      reset,
  input  wire  logic [rla_pkg::PORT_SEL_W-1:0]            port_select,
  input  wire  logic                                      reg_wr,
  input  wire  logic                                      reg_rd,
  input  wire  logic [7:0]                                reg_addr,
  input  wire  logic [7:0]                                reg_wdata,
  output logic [7:0]                                      reg_rdata,
  output logic                                            reg_rvalid,
  output logic                                            reg_hit,
  input  wire  rla_pkg::rla_fwd_load_t [NUM_PORTS-1:0]    fwd_load,
  input  wire  logic [NUM_PORTS-1:0]                      pass_all,
  input  wire  logic [NUM_PORTS-1:0][6:0]                 tgt_alias0,
  input  wire  logic [NUM_PORTS-1:0][6:0]                 tgt_alias1,
  input  wire  rla_pkg::rla_i2c_req_t                     i2c_req,
  output logic                                            route_valid,
  output rla_pkg::rla_route_t                             route,
  output logic [rla_pkg::PORT_SEL_W-1:0]                  route_port,
  output logic [NUM_PORTS-1:0][3:0]                       gpio_active
);

  // elaboration check on the port count
  if (NUM_PORTS < 1 || NUM_PORTS > rla_pkg::MAX_PORTS) begin : g_bad_ports
    $error("rla_regs: NUM_PORTS out of range");
  end

  // port-select must be wide enough to name every port
  if (NUM_PORTS > (1 << rla_pkg::PORT_SEL_W)) begin : g_narrow_sel
    $error("rla_regs: PORT_SEL_W too narrow for NUM_PORTS");
  end

  // whole state of the block
  typedef struct packed {
    rla_pkg::rla_port_regs_t [NUM_PORTS-1:0] regs;
    logic [7:0]                              rdata;
    logic                                    rvalid;
    logic                                    hit;
    logic                                    rt_valid;
    rla_pkg::rla_route_t                     rt;
    logic [rla_pkg::PORT_SEL_W-1:0]          rt_port;
  } rla_state_t;

  rla_state_t                              st;
  rla_state_t                              next_st;
  // per-port decode results, combined below
  rla_pkg::rla_route_t [NUM_PORTS-1:0]     port_route;

  // local access reaches only the port named by port_select
  function automatic logic port_chosen(input logic [rla_pkg::PORT_SEL_W-1:0] sel,
                                       input int                             p);
    port_chosen = (sel == p[rla_pkg::PORT_SEL_W-1:0]);
  endfunction

  // address decode behind the read hit flag; writes decode in their own case
  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a == rla_pkg::OFS_FWD_CFG) || (a == rla_pkg::OFS_IDENTITY)
               || (a == rla_pkg::OFS_ALIAS) || (a == rla_pkg::OFS_TGT0)
               || (a == rla_pkg::OFS_TGT1);
  endfunction

  // read image of one register; reserved bits return zero
  function automatic logic [7:0] read_byte(input rla_pkg::rla_port_regs_t r,
                                           input logic [7:0] a);
    read_byte = 8'h00;
    // bits outside a field keep this zero start
    unique case (a)
      rla_pkg::OFS_FWD_CFG: begin
        read_byte[rla_pkg::OVERRIDE_BIT]     = r.override;
        read_byte[rla_pkg::GPIO_LSB +: 2]    = r.gpio_count;
      end
      rla_pkg::OFS_IDENTITY: begin
        read_byte[rla_pkg::ADDR_LSB +: 7]    = r.identity;
        read_byte[rla_pkg::FREEZE_BIT]       = r.freeze;
      end
      rla_pkg::OFS_ALIAS: begin
        read_byte[rla_pkg::ADDR_LSB +: 7]    = r.alias_addr;
        read_byte[rla_pkg::AUTO_ACK_BIT]     = r.auto_ack;
      end
      rla_pkg::OFS_TGT0: read_byte[rla_pkg::ADDR_LSB +: 7] = r.tgt0;
      rla_pkg::OFS_TGT1: read_byte[rla_pkg::ADDR_LSB +: 7] = r.tgt1;
      default: read_byte = 8'h00;
    endcase
  endfunction

  // gpio count to active-gpio mask
  // four gpios give a full mask; no code means three
  function automatic logic [3:0] gpio_mask(input logic [1:0] cnt);
    unique case (cnt)
      2'b00: gpio_mask = 4'h0;
      2'b01: gpio_mask = 4'h1;
      2'b10: gpio_mask = 4'h3;
      2'b11: gpio_mask = 4'hF;
    endcase
  endfunction

  // one alias decoder per receive port
  // every decoder sees the same request; the lowest port wins below
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_match
    rla_alias_match u_match (
      .regs       (st.regs[p]),
      .pass_all   (pass_all[p]),
      .tgt_alias0 (tgt_alias0[p]),
      .tgt_alias1 (tgt_alias1[p]),
      .req        (i2c_req),
      .route      (port_route[p])
    );
  end

  // next-state logic
  always_comb begin
    logic wr_sel;
    wr_sel  = 1'b0;
    next_st = st;
    // answer strobes last one cycle unless raised again
    next_st.rvalid   = 1'b0;
    next_st.rt_valid = 1'b0;
    for (int p = 0; p < NUM_PORTS; p++) begin
      wr_sel = reg_wr && port_chosen(port_select, p);
      // local writes; reserved bits are never stored, so they read zero
      if (wr_sel) begin
        unique case (reg_addr)
          rla_pkg::OFS_FWD_CFG: begin
            next_st.regs[p].override   = reg_wdata[rla_pkg::OVERRIDE_BIT];
            next_st.regs[p].gpio_count = reg_wdata[rla_pkg::GPIO_LSB +: 2];
          end
          rla_pkg::OFS_IDENTITY: begin
            next_st.regs[p].identity = reg_wdata[rla_pkg::ADDR_LSB +: 7];
            next_st.regs[p].freeze   = reg_wdata[rla_pkg::FREEZE_BIT];
          end
          rla_pkg::OFS_ALIAS: begin
            next_st.regs[p].alias_addr = reg_wdata[rla_pkg::ADDR_LSB +: 7];
            next_st.regs[p].auto_ack   = reg_wdata[rla_pkg::AUTO_ACK_BIT];
          end
          rla_pkg::OFS_TGT0: next_st.regs[p].tgt0 = reg_wdata[rla_pkg::ADDR_LSB +: 7];
          rla_pkg::OFS_TGT1: next_st.regs[p].tgt1 = reg_wdata[rla_pkg::ADDR_LSB +: 7];
          default: ;
        endcase
      end
      // forward-channel loads win over a same-cycle local write
      // override and freeze act as stored, before any same-cycle write
      if (fwd_load[p].gpio_valid && !st.regs[p].override) begin
        next_st.regs[p].gpio_count = fwd_load[p].gpio_count;
      end
      if (fwd_load[p].id_valid && !st.regs[p].freeze) begin
        next_st.regs[p].identity = fwd_load[p].identity;
      end
    end
    // registered read answer
    if (reg_rd) begin
      next_st.rvalid = 1'b1;
      next_st.hit    = addr_mapped(reg_addr);
      next_st.rdata  = 8'h00;
      // a select beyond the last port finds no copy and reads zero
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (port_chosen(port_select, p)) begin
          next_st.rdata = read_byte(st.regs[p], reg_addr);
        end
      end
    end
    // routing result, lowest matching port first
    if (i2c_req.valid) begin
      next_st.rt_valid = 1'b1;
      // a request that matches nothing still answers, all zero
      next_st.rt       = '0;
      next_st.rt_port  = '0;
      for (int p = NUM_PORTS - 1; p >= 0; p--) begin
        if (port_route[p].remote) begin
          next_st.rt      = port_route[p];
          next_st.rt_port = p[rla_pkg::PORT_SEL_W-1:0];
        end
      end
    end
  end

  // state register
  // reset restores every port's register image
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st          <= '0;
      st.regs     <= {NUM_PORTS{rla_pkg::PORT_RESET}};
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state
  // read and route results leave from flip-flops only
  assign reg_rdata   = st.rdata;
  assign reg_rvalid  = st.rvalid;
  assign reg_hit     = st.hit;
  assign route_valid = st.rt_valid;
  assign route       = st.rt;
  assign route_port  = st.rt_port;

  // active forward gpio masks per port
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_gpio
    assign gpio_active[p] = gpio_mask(st.regs[p].gpio_count);
  end

endmodule

//--- sim/rla_monitor.sv
// rla_monitor: port-level checks of the remote link alias register group.
// assumes rla_regs on one clock with a synchronous active-high reset.
`timescale 1ns/10ps
module rla_monitor #(
  parameter int NUM_PORTS = 4
) (
  input wire logic                       clk_sys,
  input wire logic                       reset,
  input wire logic                       reg_rd,
  input wire logic [7:0]                 reg_addr,
  input wire logic [7:0]                 reg_rdata,
  input wire logic                       reg_rvalid,
  input wire logic                       reg_hit,
  input wire rla_pkg::rla_i2c_req_t      i2c_req,
  input wire logic                       route_valid,
  input wire rla_pkg::rla_route_t        route,
  input wire logic [NUM_PORTS-1:0][3:0]  gpio_active
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // read answer of a mapped offset
  sequence ans_s;
    reg_rvalid && reg_hit;
  endsequence
  // read request with an offset outside the group
  sequence hole_s;
    reg_rd && !(reg_addr inside {8'h59, 8'h5B, 8'h5C, 8'h5D, 8'h5E});
  endsequence
  rd_answer_a: assert property (reg_rd |=> reg_rvalid) else $error("no read answer");
  rd_pulse_a: assert property (!reg_rd |=> !reg_rvalid) else $error("stray answer");
  mapped_hit_a: assert property (reg_rd && reg_addr == 8'h5C |=> ans_s)
    else $error("mapped read missed");
  hole_read_a: assert property (hole_s |=> !reg_hit && reg_rdata == 8'h00)
    else $error("hole read not empty");
  cfg_reserved_a: assert property (reg_rd && reg_addr == 8'h59 |=> reg_rdata[6:2] == 5'h00)
    else $error("reserved config bits set");
  tgt_reserved_a: assert property (reg_rd && reg_addr inside {8'h5D, 8'h5E} |=> !reg_rdata[0])
    else $error("reserved target bit set");
  gpio_code_a: assert property (gpio_active[0] inside {4'h0, 4'h1, 4'h3, 4'hF})
    else $error("bad gpio mask");
  route_answer_a: assert property (i2c_req.valid |=> route_valid) else $error("no route");
  route_pulse_a: assert property (!i2c_req.valid |=> !route_valid) else $error("stray route");
  local_no_ack_a: assert property (route_valid && !route.remote |-> !route.ack)
    else $error("ack on local");
  ack_write_a: assert property (route_valid && route.ack |-> $past(i2c_req.is_write))
    else $error("ack on read");
endmodule

bind rla_regs rla_monitor #(.NUM_PORTS(NUM_PORTS)) mon (.clk_sys, .reset, .reg_rd, .reg_addr,
  .reg_rdata, .reg_rvalid, .reg_hit, .i2c_req, .route_valid, .route, .gpio_active);

//--- sim/rla_ser_model.sv
// rla_ser_model: far-side serializer pushing gpio count and identity loads.
// assumes the bench calls send from its own sequence.
`timescale 1ns/10ps
module rla_ser_model (
  input wire logic                      clk_sys,
  output rla_pkg::rla_fwd_load_t [3:0]  fwd_load
);
  initial fwd_load = '0;
  // one-cycle load, then stale fields flip so they are never trusted
  task automatic send(int p, logic g, logic [6:0] v);
    @(posedge clk_sys);
    #2;
    fwd_load[p] = {g, v[1:0], !g, v};
    @(posedge clk_sys);
    #2;
    fwd_load[p] = {1'b0, ~v[1:0], 1'b0, ~v};
  endtask
endmodule

//--- sim/tb.sv
// tb: self-checking bench of rla_regs against a reference register image.
// assumes rla_ser_model as far side and rla_monitor bound into the design.
`timescale 1ns/10ps
module tb;
  logic clk_sys, reset, reg_wr, reg_rd, reg_rvalid, reg_hit, route_valid;
  logic [1:0] port_select, route_port;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, a;
  logic [7:0] rm[4][6];
  logic [7:0] msk[6] = '{8'h83, 8'h00, 8'hFF, 8'hFF, 8'hFE, 8'hFE};
  logic [3:0] pass_all;
  logic [3:0][6:0] tgt_alias0, tgt_alias1;
  logic [3:0][3:0] gpio_active;
  rla_pkg::rla_fwd_load_t [3:0] fwd_load;
  rla_pkg::rla_i2c_req_t i2c_req;
  rla_pkg::rla_route_t route;
  int err_count, tests_run, seed, p;
  rla_regs #(.NUM_PORTS(4)) uut (.clk_sys, .reset, .port_select, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .reg_rdata, .reg_rvalid, .reg_hit, .fwd_load, .pass_all, .tgt_alias0,
    .tgt_alias1, .i2c_req, .route_valid, .route, .route_port, .gpio_active);
  rla_ser_model ser (.clk_sys, .fwd_load);
  // clock
  initial begin
    clk_sys = 0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // watchdog
  initial begin
    #300000;
    err_count++;
    end_of_test;
  end
  // one compare per kind of result: register read, gpio mask, route
  task automatic cmp_rd(string n, logic [8:0] e, logic [8:0] s);
    tests_run++;
    if (s !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic cmp_gp(int q, logic [3:0] e, logic [3:0] s);
    tests_run++;
    if (s !== e) begin
      err_count++;
      $display("BAD gpio%0d exp %h got %h", q, e, s);
    end
  endtask
  task automatic cmp_rt(string n, logic [9:0] e, logic [9:0] s);
    tests_run++;
    if (s !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic end_of_test;
    $display("errors %0d checks %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic wr(int q, logic [7:0] b, logic [7:0] d);
    @(posedge clk_sys);
    #2;
    {reg_wr, port_select, reg_addr, reg_wdata} = {1'b1, q[1:0], b, d};
    @(posedge clk_sys);
    #2;
    reg_wr = 0;
    if (b inside {[8'h59:8'h5E]}) rm[q][b-8'h59] = d & msk[b-8'h59];
  endtask
  task automatic rd(int q, logic [7:0] b);
    logic m;
    m = b inside {[8'h59:8'h5E]} && b != 8'h5A;
    @(posedge clk_sys);
    #2;
    {reg_rd, port_select, reg_addr} = {1'b1, q[1:0], b};
    @(posedge clk_sys);
    #2;
    reg_rd = 0;
    cmp_rd("rdata", {1'b1, m ? rm[q][b-8'h59] : 8'h00}, {reg_rvalid, reg_rdata});
    cmp_rd("hit", 9'(m), 9'(reg_hit));
  endtask
  task automatic chk_gp;
    logic [3:0] e;
    for (int q = 0; q < 4; q++) begin
      e = rm[q][0][1:0] == 2'd3 ? 4'hF : (4'h1 << rm[q][0][1:0]) - 4'h1;
      cmp_gp(q, e, gpio_active[q]);
    end
  endtask
  task automatic ld(int q, logic g, logic [6:0] v);
    ser.send(q, g, v);
    if (g && !rm[q][0][7]) rm[q][0][1:0] = v[1:0];
    if (!g && !rm[q][2][0]) rm[q][2][7:1] = v;
  endtask
  task automatic rq(logic [6:0] b, logic w);
    logic [9:0] f;
    logic [8:0] e;
    int ep;
    e = 0;
    ep = 0;
    for (int q = 3; q >= 0; q--) begin
      f = 0;
      if (rm[q][3][7:1] != 0 && b == rm[q][3][7:1]) f = {2'b11, w & rm[q][3][0], rm[q][4][7:1]};
      else if (b == tgt_alias0[q]) f = {3'b110, rm[q][4][7:1]};
      else if (b == tgt_alias1[q]) f = {3'b110, rm[q][5][7:1]};
      else if (pass_all[q]) f = {3'b110, b};
      if (f[9]) {e, ep} = {f[8:0], q};
    end
    @(posedge clk_sys);
    #2;
    i2c_req = {1'b1, w, b};
    @(posedge clk_sys);
    #2;
    i2c_req.valid = 0;
    cmp_rt("route", {1'b1, e}, {route_valid, route});
    if (e[8]) cmp_rt("port", 10'(ep), 10'(route_port));
  endtask
  initial begin
    seed = 32'hf6a6f0ac;
    {reset, reg_wr, reg_rd, port_select, reg_addr, reg_wdata, pass_all} = '0;
    i2c_req = '0;
    rm = '{default: 8'h00};
    for (int q = 0; q < 4; q++) {tgt_alias0[q], tgt_alias1[q]} = {7'h20 + 7'(q), 7'h30 + 7'(q)};
    reset = 1;
    repeat (16) @(posedge clk_sys);
    #2 reset = 0;
    // reset values and holes on every port
    for (int i = 0; i < 32; i++) rd(i / 8, 8'h58 + 8'(i % 8));
    // random writes read back through the port select
    repeat (60) begin
      p = {$random(seed)} % 4;
      a = 8'h58 + 8'({$random(seed)} % 8);
      wr(p, a, 8'($random(seed)));
      rd(p, a);
      chk_gp;
    end
    // forward loads against override and freeze
    for (int k = 0; k < 16; k++) begin
      p = k % 4;
      wr(p, 8'h59, {k[2], 5'h1F, k[1:0]});
      wr(p, 8'h5B, {7'h11, k[3]});
      ld(p, 1, 7'(k + 1));
      ld(p, 0, 7'(k * 5 + 9));
      rd(p, 8'h59);
      rd(p, 8'h5B);
      chk_gp;
    end
    // mid-run reset returns every port to its reset image
    @(posedge clk_sys);
    #2 reset = 1;
    repeat (2) @(posedge clk_sys);
    #2 reset = 0;
    rm = '{default: 8'h00};
    for (int i = 0; i < 32; i++) rd(i / 8, 8'h58 + 8'(i % 8));
    chk_gp;
    // alias, target aliases, pass-through and disabled alias
    for (int k = 0; k < 8; k++) begin
      p = k % 4;
      wr(p, 8'h5C, {k < 4 ? 7'h40 + 7'(k) : 7'h00, k[0]});
      wr(p, 8'h5D, 8'($random(seed)));
      wr(p, 8'h5E, 8'($random(seed)));
      pass_all = 4'($random(seed));
      rq(7'h40 + 7'(p), k[1]);
      rq(7'h00, 1);
      rq(tgt_alias0[p], 1);
      rq(tgt_alias1[p], 0);
      rq(7'h7F, 1);
    end
    end_of_test;
  end
endmodule
